// ===== pcr_pkg.sv
package pcr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] PCR_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCR_OFF_CMD = 8'h04;
    localparam logic [7:0] PCR_OFF_STATUS = 8'h08;
    localparam logic [7:0] PCR_OFF_COUNT = 8'h0c;
    localparam logic [7:0] PCR_OFF_RELOAD = 8'h10;
    localparam logic [7:0] PCR_OFF_RELOAD_BUF = 8'h14;
    localparam logic [7:0] PCR_OFF_IF = 8'h18;
    localparam logic [7:0] PCR_OFF_FLAG_SET = 8'h1c;
    localparam logic [7:0] PCR_OFF_FLAG_CLR = 8'h20;
    localparam logic [7:0] PCR_OFF_IRQ_EN = 8'h24;
    localparam logic [7:0] PCR_OFF_ROUTE = 8'h28;
    localparam logic [7:0] PCR_OFF_HOLD = 8'h2c;
    localparam logic [7:0] PCR_OFF_BUSY = 8'h30;
    // ==========================================================
    // Field positions
    localparam int PCR_CMD_LOAD_COUNT_BIT = 0;
    localparam int PCR_CMD_LOAD_BUF_BIT = 1;
    localparam int PCR_FLAG_UNDER = 0;
    localparam int PCR_FLAG_OF = 1;
    localparam int PCR_FLAG_DIR = 2;
    localparam int PCR_FLAG_AUX = 3;
    localparam int PCR_LOC_LSB = 8;
    localparam int PCR_LOC_MSB = 10;
    localparam int PCR_BUSY_CTRL = 0;
    localparam int PCR_BUSY_CMD = 1;
    localparam int PCR_BUSY_BUF = 2;
    localparam int PCR_MODE_MSB = 1;
    // ==========================================================
    // Reset values and encodings
    localparam logic [15:0] PCR_COUNT_RST = 16'h0000;
    localparam logic [15:0] PCR_RELOAD_RST = 16'h00ff;
    localparam logic [1:0] PCR_MODE_QUAD = 2'h3;
    localparam logic [1:0] PCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCR_RESP_SLVERR = 2'h2;
    // ==========================================================
    // Counter clock: 32768 Hz derived from 50 MHz
    localparam int PCR_CLK_HZ = 50000000;
    localparam int PCR_SLOW_CLK_HZ = 32768;
    localparam int PCR_SLOW_DIV = PCR_CLK_HZ / PCR_SLOW_CLK_HZ;
endpackage

// ===== pcr_core.sv
`timescale 1ns/100ps
module pcr_core
    import pcr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic tick_in,
    input wire logic up_pulse_in,
    input wire logic down_pulse_in,
    input wire logic quad_mode_in,
    input wire logic load_count_in,
    input wire logic load_top_in,
    input wire logic [WIDTH-1:0] top_buf_in,
    output logic [WIDTH-1:0] count_out,
    output logic [WIDTH-1:0] top_out,
    output logic dir_out,
    output logic of_out,
    output logic under_out,
    output logic dir_chg_out
);
    // ==========================================================
    // Counter in the slow domain, advancing on tick
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] top_reg;
    logic dir_reg;
    logic load_pend_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            top_reg <= PCR_RELOAD_RST;
        end else if (load_top_in) begin
            top_reg <= top_buf_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            load_pend_reg <= 1'b0;
        end else if (load_count_in) begin
            load_pend_reg <= 1'b1;
        end else if (tick_in) begin
            load_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            count_reg <= PCR_COUNT_RST;
            dir_reg <= 1'b0;
            of_out <= 1'b0;
            under_out <= 1'b0;
            dir_chg_out <= 1'b0;
        end else begin
            of_out <= 1'b0;
            under_out <= 1'b0;
            dir_chg_out <= 1'b0;
            if (tick_in) begin
                if (load_pend_reg) begin
                    count_reg <= top_reg;
                end else if (up_pulse_in && !down_pulse_in) begin
                    if (count_reg == top_reg) begin
                        count_reg <= '0;
                        of_out <= 1'b1;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end else if (down_pulse_in && !up_pulse_in) begin
                    if (count_reg == '0) begin
                        count_reg <= top_reg;
                        under_out <= 1'b1;
                    end else begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
                if (up_pulse_in != down_pulse_in) begin
                    dir_reg <= down_pulse_in;
                    if (quad_mode_in && (dir_reg != down_pulse_in)) begin
                        dir_chg_out <= 1'b1;
                    end
                end
            end
        end
    end

    assign count_out = count_reg;
    assign top_out = top_reg;
    assign dir_out = dir_reg;

    a_top_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        load_top_in |=> top_reg == $past(top_buf_in)) else $error("reload not loaded");
    a_under_wrap: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        under_out |-> count_reg == $past(top_reg)) else $error("underflow not reloaded");
    a_of_wrap: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        of_out |-> count_reg == '0) else $error("overflow not cleared");
endmodule

// ===== pcr_regs.sv
`timescale 1ns/100ps
module pcr_regs
    import pcr_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DIV = PCR_SLOW_DIV
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic up_pulse_in,
    input wire logic down_pulse_in,
    input wire logic aux_overflow_in,
    output logic [1:0] pin_location_out,
    output logic [1:0] mode_out,
    output logic irq_out
);
    // ==========================================================
    // Write channel
    logic aw_have_reg;
    logic w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic wr_hit;

    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign wr_fire = aw_have_reg && w_have_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_addr_reg)
            PCR_OFF_CTRL, PCR_OFF_CMD, PCR_OFF_STATUS, PCR_OFF_COUNT, PCR_OFF_RELOAD,
            PCR_OFF_RELOAD_BUF, PCR_OFF_IF, PCR_OFF_FLAG_SET, PCR_OFF_FLAG_CLR, PCR_OFF_IRQ_EN,
            PCR_OFF_ROUTE, PCR_OFF_HOLD, PCR_OFF_BUSY: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic wr_to(input logic [7:0] off);
        return wr_fire && (aw_addr_reg == off);
    endfunction

    // ==========================================================
    // Software-facing registers
    logic [15:0] ctrl_reg;
    logic [WIDTH-1:0] reload_buf_reg;
    logic [3:0] irq_en_reg;
    logic [2:0] loc_reg;
    logic hold_reg;
    logic [3:0] flags_reg;
    logic [3:0] flag_evt;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= 16'h0000;
            reload_buf_reg <= PCR_RELOAD_RST;
            irq_en_reg <= 4'h0;
            loc_reg <= 3'h0;
            hold_reg <= 1'b0;
        end else begin
            if (wr_to(PCR_OFF_CTRL) && w_strb_reg[0]) ctrl_reg[7:0] <= w_data_reg[7:0];
            if (wr_to(PCR_OFF_CTRL) && w_strb_reg[1]) ctrl_reg[15:8] <= w_data_reg[15:8];
            if (wr_to(PCR_OFF_RELOAD_BUF) && w_strb_reg[0]) begin
                reload_buf_reg[7:0] <= w_data_reg[7:0];
            end
            if (wr_to(PCR_OFF_RELOAD_BUF) && w_strb_reg[1]) begin
                reload_buf_reg[15:8] <= w_data_reg[15:8];
            end
            if (wr_to(PCR_OFF_IRQ_EN) && w_strb_reg[0]) irq_en_reg <= w_data_reg[3:0];
            if (wr_to(PCR_OFF_ROUTE) && w_strb_reg[1]) begin
                loc_reg <= w_data_reg[PCR_LOC_MSB:PCR_LOC_LSB];
            end
            if (wr_to(PCR_OFF_HOLD) && w_strb_reg[0]) hold_reg <= w_data_reg[0];
        end
    end

    assign pin_location_out = loc_reg[1:0];

    // ==========================================================
    // Slow-domain transfer: pending updates wait for tick and no hold
    logic [$clog2(DIV)-1:0] div_reg;
    logic tick;
    logic pend_ctrl_reg;
    logic pend_cmd_reg;
    logic pend_buf_reg;
    logic [1:0] pend_cmd_bits_reg;
    logic [15:0] ctrl_sync_reg;
    logic [WIDTH-1:0] buf_sync_reg;
    logic xfer;
    logic load_count_now;
    logic load_buffer_now;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            div_reg <= '0;
        end else if (div_reg == $bits(div_reg)'(DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign tick = (div_reg == $bits(div_reg)'(DIV - 1));
    assign xfer = tick && !hold_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pend_ctrl_reg <= 1'b0;
            pend_cmd_reg <= 1'b0;
            pend_buf_reg <= 1'b0;
            pend_cmd_bits_reg <= 2'h0;
        end else begin
            if (wr_to(PCR_OFF_CTRL)) pend_ctrl_reg <= 1'b1;
            else if (xfer) pend_ctrl_reg <= 1'b0;
            if (wr_to(PCR_OFF_RELOAD_BUF)) pend_buf_reg <= 1'b1;
            else if (xfer) pend_buf_reg <= 1'b0;
            if (wr_to(PCR_OFF_CMD) && w_strb_reg[0]) begin
                pend_cmd_reg <= 1'b1;
                pend_cmd_bits_reg <= pend_cmd_bits_reg | w_data_reg[1:0];
            end else if (xfer) begin
                pend_cmd_reg <= 1'b0;
                pend_cmd_bits_reg <= 2'h0;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_sync_reg <= 16'h0000;
            buf_sync_reg <= PCR_RELOAD_RST;
        end else if (xfer) begin
            ctrl_sync_reg <= ctrl_reg;
            buf_sync_reg <= reload_buf_reg;
        end
    end

    assign load_count_now = xfer && pend_cmd_bits_reg[PCR_CMD_LOAD_COUNT_BIT];
    assign load_buffer_now = xfer && pend_cmd_bits_reg[PCR_CMD_LOAD_BUF_BIT];
    assign mode_out = ctrl_sync_reg[PCR_MODE_MSB:0];

    // ==========================================================
    // Counter
    logic [WIDTH-1:0] count_value;
    logic [WIDTH-1:0] reload_value;
    logic dir;
    logic of_evt;
    logic under_evt;
    logic dir_evt;

    pcr_core #(
        .WIDTH(WIDTH)
    ) pcr_core_inst (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .up_pulse_in(up_pulse_in),
        .down_pulse_in(down_pulse_in),
        .quad_mode_in(mode_out == PCR_MODE_QUAD),
        .load_count_in(load_count_now),
        .load_top_in(load_buffer_now),
        .top_buf_in(pend_buf_reg ? reload_buf_reg : buf_sync_reg),
        .count_out(count_value),
        .top_out(reload_value),
        .dir_out(dir),
        .of_out(of_evt),
        .under_out(under_evt),
        .dir_chg_out(dir_evt)
    );

    // ==========================================================
    // Interrupt flags: hardware set wins over clear
    assign flag_evt = {aux_overflow_in, dir_evt, of_evt, under_evt};

    for (genvar i = 0; i < 4; i++) begin : g_flag
        logic set_sw;
        logic clr_sw;
        assign set_sw = wr_to(PCR_OFF_FLAG_SET) && w_strb_reg[0] && w_data_reg[i];
        assign clr_sw = wr_to(PCR_OFF_FLAG_CLR) && w_strb_reg[0] && w_data_reg[i];
        always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
                flags_reg[i] <= 1'b0;
            end else if (flag_evt[i] || set_sw) begin
                flags_reg[i] <= 1'b1;
            end else if (clr_sw) begin
                flags_reg[i] <= 1'b0;
            end
        end
    end

    assign irq_out = |(flags_reg & irq_en_reg);

    // ==========================================================
    // Read channel
    logic [31:0] rd_mux;
    logic rd_hit;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        unique case (s_axi_araddr)
            PCR_OFF_CTRL: rd_mux = {16'h0, ctrl_reg};
            PCR_OFF_STATUS: rd_mux = {31'h0, dir};
            PCR_OFF_COUNT: rd_mux = {16'h0, count_value};
            PCR_OFF_RELOAD: rd_mux = {16'h0, reload_value};
            PCR_OFF_RELOAD_BUF: rd_mux = {16'h0, reload_buf_reg};
            PCR_OFF_IF: rd_mux = {28'h0, flags_reg};
            PCR_OFF_IRQ_EN: rd_mux = {28'h0, irq_en_reg};
            PCR_OFF_ROUTE: rd_mux = {21'h0, loc_reg, 8'h00};
            PCR_OFF_HOLD: rd_mux = {31'h0, hold_reg};
            PCR_OFF_BUSY: rd_mux = {29'h0, pend_buf_reg, pend_cmd_reg, pend_ctrl_reg};
            PCR_OFF_CMD, PCR_OFF_FLAG_SET, PCR_OFF_FLAG_CLR: rd_mux = 32'h0;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= PCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? PCR_RESP_OKAY : PCR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_irq_level: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_to(PCR_OFF_IRQ_EN) && w_strb_reg[0] && |(w_data_reg[3:0] & flags_reg)
        |=> irq_out) else $error("irq not raised");
    a_flag_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        of_evt |=> flags_reg[PCR_FLAG_OF]) else $error("overflow flag missed");
    a_under_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        under_evt |=> flags_reg[PCR_FLAG_UNDER]) else $error("underflow flag missed");
    a_aux_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        aux_overflow_in |=> flags_reg[PCR_FLAG_AUX]) else $error("aux flag missed");
    a_hold_blocks: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        hold_reg |-> !load_count_now && !load_buffer_now) else $error("write leaked");
    a_busy_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        xfer && !wr_fire |=> !pend_buf_reg && !pend_cmd_reg) else $error("busy stuck");
    a_ctrl_busy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wr_to(PCR_OFF_CTRL) |=> pend_ctrl_reg) else $error("ctrl busy missing");
    a_dir_quad: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        dir_evt |-> $past(mode_out) == PCR_MODE_QUAD) else $error("dir flag out of mode");
endmodule

// ===== pcr_axi_master.sv
`timescale 1ns/100ps
// ==========================================================
// Bus master standing in for the processor software
module pcr_axi_master (
    input wire logic clock_in,
    output logic [7:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    output logic [7:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    // Payload is scrambled once taken so a stale value is never reused
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock_in);
        awaddr_out <= a;
        wdata_out <= d;
        awvalid_out <= 1'b1;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        forever begin
            @(posedge clock_in);
            if (awvalid_out && awready_in) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (wvalid_out && wready_in) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
            if (bvalid_in) begin
                r = bresp_in;
                bready_out <= 1'b0;
                break;
            end
        end
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_in);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        forever begin
            @(posedge clock_in);
            if (arvalid_out && arready_in) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
            if (rvalid_in) begin
                d = rdata_in;
                r = rresp_in;
                rready_out <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ===== pcr_regs_tb_top.sv
`timescale 1ns/100ps
module pcr_regs_tb_top
    import pcr_pkg::*;
;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, loc, mode;
    logic up = 1'b0;
    logic down = 1'b0;
    logic aux = 1'b0;
    logic irq;
    int err_count = 0;
    int n_checks = 0;
    always #10 clock_in = ~clock_in;
    pcr_regs #(.DIV(4)) pcr_regs_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .up_pulse_in(up), .down_pulse_in(down), .aux_overflow_in(aux),
        .pin_location_out(loc), .mode_out(mode), .irq_out(irq));
    pcr_axi_master pcr_axi_master_inst (.clock_in(clock_in), .awaddr_out(awaddr),
        .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata), .wvalid_out(wvalid),
        .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
        .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
        .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        pcr_axi_master_inst.write_reg(a, d, r);
        check("write resp", {30'h0, PCR_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string name);
        logic [31:0] d;
        logic [1:0] r;
        pcr_axi_master_inst.read_reg(a, d, r);
        check("read resp", {30'h0, PCR_RESP_OKAY}, {30'h0, r});
        check(name, e, d & m);
    endtask
    // Re-read until the masked value equals the expected one, at most 40 reads
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string name);
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 40; i++) begin
            pcr_axi_master_inst.read_reg(a, d, r);
            if ((d & m) === e) break;
        end
        check(name, e, d & m);
    endtask
    task automatic pulse_dir(input bit go_up);
        @(posedge clock_in);
        if (go_up) up <= 1'b1; else down <= 1'b1;
        repeat (4) @(posedge clock_in);
        up <= 1'b0;
        down <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] a[9] = '{PCR_OFF_STATUS, PCR_OFF_COUNT, PCR_OFF_RELOAD, PCR_OFF_RELOAD_BUF,
            PCR_OFF_IF, PCR_OFF_IRQ_EN, PCR_OFF_ROUTE, PCR_OFF_HOLD, PCR_OFF_BUSY};
        logic [31:0] e[9] = '{32'h0, 32'h0, 32'h00ff, 32'h00ff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 9; i++) rdc(a[i], 32'hffffffff, e[i], "reset value");
        wr(PCR_OFF_COUNT, 32'h1234);
        wr(PCR_OFF_RELOAD, 32'h1234);
        rdc(PCR_OFF_COUNT, 32'hffffffff, 32'h0, "count read only");
        rdc(PCR_OFF_RELOAD, 32'hffffffff, 32'h00ff, "reload read only");
        pcr_axi_master_inst.read_reg(8'h3c, d, r);
        check("unmapped resp", {30'h0, PCR_RESP_SLVERR}, {30'h0, r});
        pcr_axi_master_inst.write_reg(8'h3c, 32'h0, r);
        check("unmapped write resp", {30'h0, PCR_RESP_SLVERR}, {30'h0, r});
    endtask
    task automatic t_reload();
        wr(PCR_OFF_RELOAD_BUF, 32'h00010005);
        rdc(PCR_OFF_RELOAD_BUF, 32'hffffffff, 32'h0005, "buffer");
        poll(PCR_OFF_BUSY, 32'h4, 32'h0, "busy buffer");
        wr(PCR_OFF_CMD, 32'h0);
        repeat (12) @(posedge clock_in);
        rdc(PCR_OFF_RELOAD, 32'hffffffff, 32'h00ff, "reload zero cmd");
        wr(PCR_OFF_CMD, 32'h2);
        poll(PCR_OFF_RELOAD, 32'hffffffff, 32'h0005, "reload load");
        rdc(PCR_OFF_CMD, 32'hffffffff, 32'h0, "cmd read");
    endtask
    task automatic t_count();
        wr(PCR_OFF_CTRL, {30'h0, PCR_MODE_QUAD});
        poll(PCR_OFF_BUSY, 32'h1, 32'h0, "busy ctrl");
        check("mode", {30'h0, PCR_MODE_QUAD}, {30'h0, mode});
        wr(PCR_OFF_CMD, 32'h1);
        poll(PCR_OFF_COUNT, 32'hffffffff, 32'h0005, "count load");
        rdc(PCR_OFF_IF, 32'hf, 32'h0, "flags idle");
        pulse_dir(1'b1);
        rdc(PCR_OFF_COUNT, 32'hffffffff, 32'h0, "count wrap up");
        rdc(PCR_OFF_IF, 32'hf, 32'h2, "overflow flag");
        pulse_dir(1'b0);
        rdc(PCR_OFF_COUNT, 32'hffffffff, 32'h0005, "count wrap down");
        rdc(PCR_OFF_IF, 32'hf, 32'h7, "underflow dir flags");
        rdc(PCR_OFF_STATUS, 32'hffffffff, 32'h1, "direction");
        wr(PCR_OFF_CTRL, 32'h0);
        poll(PCR_OFF_BUSY, 32'h1, 32'h0, "busy ctrl off");
        check("mode off", 32'h0, {30'h0, mode});
        wr(PCR_OFF_FLAG_CLR, 32'h4);
        pulse_dir(1'b1);
        rdc(PCR_OFF_IF, 32'h4, 32'h0, "no dir flag outside quad");
        rdc(PCR_OFF_STATUS, 32'hffffffff, 32'h0, "direction up");
    endtask
    task automatic t_flags();
        wr(PCR_OFF_FLAG_CLR, 32'hf);
        rdc(PCR_OFF_IF, 32'hffffffff, 32'h0, "flag clear all");
        @(posedge clock_in);
        aux <= 1'b1;
        @(posedge clock_in);
        aux <= 1'b0;
        rdc(PCR_OFF_IF, 32'hffffffff, 32'h8, "aux flag");
        wr(PCR_OFF_FLAG_SET, 32'h3);
        rdc(PCR_OFF_IF, 32'hffffffff, 32'hb, "flag set");
        wr(PCR_OFF_FLAG_CLR, 32'h1);
        wr(PCR_OFF_IF, 32'h0);
        rdc(PCR_OFF_IF, 32'hffffffff, 32'ha, "flag clear one");
        @(negedge clock_in);
        check("irq none", 32'h0, {31'h0, irq});
        wr(PCR_OFF_IRQ_EN, 32'h1);
        @(negedge clock_in);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(PCR_OFF_IRQ_EN, 32'h2);
        @(negedge clock_in);
        check("irq raised", 32'h1, {31'h0, irq});
        rdc(PCR_OFF_IRQ_EN, 32'hffffffff, 32'h2, "enable");
        wr(PCR_OFF_FLAG_CLR, 32'h2);
        @(negedge clock_in);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask
    task automatic t_hold();
        wr(PCR_OFF_HOLD, 32'h1);
        wr(PCR_OFF_RELOAD_BUF, 32'h0033);
        wr(PCR_OFF_CMD, 32'h2);
        repeat (20) @(posedge clock_in);
        rdc(PCR_OFF_BUSY, 32'h6, 32'h6, "busy held");
        rdc(PCR_OFF_RELOAD, 32'hffffffff, 32'h0005, "reload held");
        wr(PCR_OFF_HOLD, 32'h0);
        poll(PCR_OFF_BUSY, 32'h7, 32'h0, "busy released");
        rdc(PCR_OFF_RELOAD, 32'hffffffff, 32'h0033, "reload released");
    endtask
    task automatic t_route();
        wr(PCR_OFF_ROUTE, 32'hffffffff);
        rdc(PCR_OFF_ROUTE, 32'hffffffff, 32'h0700, "location");
        @(negedge clock_in);
        check("location pins", 32'h3, {30'h0, loc});
    endtask
    // ==========================================================
    // Sequence and verdict
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_reload();
        t_count();
        t_flags();
        t_hold();
        t_route();
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge clock_in);
        err_count++;
        finish_test();
    end
endmodule
